/* File: pmrc_pkg.sv */
// package for the power-mode and reset controller: offsets, fields, reset values, timing
// assumes a 25 MHz system clock and an APB slave with 32-bit data
package pmrc_pkg;

    // ==========================================================
    // register map (printed offsets are not all word aligned, so they are indices)
    localparam logic [7:0] power_control_idx = 8'h87;
    localparam logic [7:0] supply_monitor_control_idx = 8'hff;
    localparam logic [7:0] reset_cause_idx = 8'hef;
    localparam logic [9:0] power_control_addr = {power_control_idx, 2'b00};
    localparam logic [9:0] supply_monitor_control_addr = {supply_monitor_control_idx, 2'b00};
    localparam logic [9:0] reset_cause_addr = {reset_cause_idx, 2'b00};

    // ==========================================================
    // field positions
    localparam int idle_bit = 0;
    localparam int stop_bit = 1;
    localparam int flags_lsb = 2;
    localparam int monitor_on_bit = 7;
    localparam int above_bit = 6;
    localparam int pin_flag_bit = 0;
    localparam int powerup_flag_bit = 1;
    localparam int lost_clock_bit = 2;

    // ==========================================================
    // reset values
    localparam logic [5:0] general_flags_reset = 6'h00;
    localparam logic [15:0] start_address = 16'h0000;
    localparam logic [7:0] port_latch_reset = 8'hff;

    // ==========================================================
    // timing
    localparam int clk_mhz = 25;
    localparam int powerup_delay_us = 300;
    localparam int powerup_delay_cycles = powerup_delay_us * clk_mhz;
    localparam int lost_clock_timeout_us = 100;
    localparam int lost_clock_cycles = lost_clock_timeout_us * clk_mhz;
    localparam int monitor_turn_on_us = 100;
    localparam int monitor_settle_cycles = monitor_turn_on_us * clk_mhz;

    // ==========================================================
    // sequencer states, gray along the usual path
    typedef enum logic [2:0] {
        st_hold = 3'b000,
        st_delay = 3'b001,
        st_run = 3'b011,
        st_idle = 3'b010,
        st_stop = 3'b110
    } seq_state_type;

    // reset cause
    typedef enum logic [1:0] {
        cause_power = 2'h0,
        cause_pin = 2'h1,
        cause_lost_clock = 2'h2,
        cause_monitor = 2'h3
    } cause_type;

    // what the core sees
    typedef struct packed {
        logic cpu_clock_en;
        logic periph_clock_en;
        logic osc_run;
        logic core_reset;
        logic fetch_restart;
    } core_ctl_type;

endpackage : pmrc_pkg

/* File: pmrc_sync.sv */
// two-flop synchroniser for a level from outside the clock domain
// assumes the input is a slow level, held many cycles
`timescale 1ns/100ps
`default_nettype none
module pmrc_sync (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic ce,
    input wire logic async_in,
    input wire logic reset_value,
    output logic sync_out
);
    typedef struct packed {
        logic first;
        logic second;
    } sync_state_type;

    sync_state_type state_q;
    sync_state_type state_d;

    // =====================================================
    // first flop only feeds the second
    always_comb begin
        state_d = state_q;
        state_d.first = async_in;
        state_d.second = state_q.first;
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            state_q <= '0;
        end else if (ce) begin
            state_q <= state_d;
        end
    end

    assign sync_out = rst_b ? state_q.second : reset_value;
endmodule : pmrc_sync
`default_nettype wire

/* File: pmrc_counter.sv */
// down counter for reset delays and timeouts
// assumes load and enable come from logic on the same clock
`timescale 1ns/100ps
`default_nettype none
module pmrc_counter #(
    parameter int width = 16
) (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic ce,
    input wire logic load,
    input wire logic [width-1:0] load_value,
    input wire logic count_en,
    output logic done
);
    typedef struct packed {
        logic [width-1:0] count;
    } cnt_state_type;

    cnt_state_type state_q;
    cnt_state_type state_d;

    // =====================================================
    // load wins over counting
    always_comb begin
        state_d = state_q;
        if (load) begin
            state_d.count = load_value;
        end else if (count_en && state_q.count != '0) begin
            state_d.count = state_q.count - 1'b1;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            state_q <= '0;
        end else if (ce) begin
            state_q <= state_d;
        end
    end

    assign done = (state_q.count == '0) && !load;
endmodule : pmrc_counter
`default_nettype wire

/* File: power_modes_reset_control.sv */
// power-mode and reset controller: idle, stop, suspend wake, reset sequencing
// assumes APB master on clk; supply, pin and usb status arrive asynchronously
// What this block does
// - idle bit stops cpu clock after instruction, peripherals run, reads zero
// - enabled interrupt ends idle, cpu resumes after the idle instruction
// - reset during idle runs normal reset sequence from address zero
// - stop bit halts oscillator, cpu, digital peripherals; reads zero
// - only a reset leaves stop, then normal sequence from zero
// - enabled lost clock watch resets out of stop; software disables it
// - upper six power control bits are plain software flags
// - suspended oscillator waits for usb event or matching bus power level
// - reset halts execution, resets registers, ports, interrupts, timers
// - port latches all ones open drain, pullups on during and after
// - power-on and monitor resets drive reset pin low throughout
// - leaving reset clears pc, selects internal oscillator, starts at zero
// - power-up holds reset until supply good, then powerup delay
// - power-on and monitor resets set powerup flag; pin and lost clock resets clear it
// - monitor enabled after power-on; other resets keep its state
// - writing one to pin reset flag forces a power-on reset
// - supply below trip with monitor selected drives pin low, holds core until recovered
// - selecting unsettled monitor as reset source causes a reset
// - bit seven switches monitor; resets need it selected, and a selected monitor that is off resets too
// - bit six shows live monitor output, read only
// - low reset pin resets device; pin flag set on exit
// - lost clock watch resets after timeout without clock edges
//
// Local design decision: the APB interface to the registers.
`timescale 1ns/100ps
`default_nettype none
module power_modes_reset_control #(
    parameter int powerup_cycles = pmrc_pkg::powerup_delay_cycles,
    parameter int lost_clock_limit = pmrc_pkg::lost_clock_cycles,
    parameter int settle_cycles = pmrc_pkg::monitor_settle_cycles
) (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic ce,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // core side
    input wire logic instr_done,
    input wire logic irq_pending,
    input wire logic clock_edge_seen,
    input wire logic osc_suspend,
    input wire logic usb_event,
    input wire logic bus_power,
    input wire logic bus_power_polarity,
    input wire logic supply_good_async,
    // reset pin, open drain
    input wire logic reset_pin_n_in,
    output logic reset_pin_out,
    output logic reset_pin_oe,
    // core controls
    output pmrc_pkg::core_ctl_type core_ctl,
    output logic [15:0] fetch_address,
    output logic [7:0] port_latch,
    output logic port_open_drain,
    output logic weak_pullup_en,
    output logic supply_monitor_on,
    output logic [5:0] general_flags
);
    typedef struct packed {
        pmrc_pkg::seq_state_type state;
        pmrc_pkg::cause_type cause;
        logic [5:0] flags;
        logic idle_req;
        logic stop_req;
        logic monitor_on;
        logic monitor_select;
        logic lost_clock_en;
        logic powerup_flag;
        logic pin_flag;
        logic lost_clock_flag;
        logic pin_drive;
        logic [1:0] pin_mask;
        logic sw_por;
        logic [31:0] rdata;
    } ctl_state_type;

    ctl_state_type state_q;
    ctl_state_type state_d;

    logic supply_good;
    logic pin_low;
    logic usb_wake;
    logic pin_n_sync;
    logic delay_done;
    logic delay_load;
    logic settle_done;
    logic settle_load;
    logic watch_done;
    logic watch_load;
    logic apb_write;
    logic apb_read;
    logic [9:0] word_addr;
    logic mapped;
    logic monitor_fault;
    logic lost_clock;
    logic wake_event;

    // =====================================================
    // synchronisers for asynchronous inputs
    pmrc_sync u_sync_supply (
        .clk(clk),
        .rst_b(rst_b),
        .ce(ce),
        .async_in(supply_good_async),
        .reset_value(1'b0),
        .sync_out(supply_good)
    );

    pmrc_sync u_sync_pin (
        .clk(clk),
        .rst_b(rst_b),
        .ce(ce),
        .async_in(reset_pin_n_in),
        .reset_value(1'b1),
        .sync_out(pin_n_sync)
    );

    pmrc_sync u_sync_usb (
        .clk(clk),
        .rst_b(rst_b),
        .ce(ce),
        .async_in(usb_event),
        .reset_value(1'b0),
        .sync_out(usb_wake)
    );

    // our own drive shows on the pin too; ignore it as an external reset,
    // also for the two cycles the synchroniser still shows it after release
    assign pin_low = !pin_n_sync && !state_q.pin_drive && (state_q.pin_mask == 2'b00);

    // =====================================================
    // timers: powerup delay, monitor settle, lost clock watch
    // powerup delay count
    assign delay_load = (state_q.state != pmrc_pkg::st_delay);
    pmrc_counter #(
        .width(24)
    ) u_delay (
        .clk(clk),
        .rst_b(rst_b),
        .ce(ce),
        .load(delay_load),
        .load_value(24'(powerup_cycles)),
        .count_en(1'b1),
        .done(delay_done)
    );

    // settle restarts whenever the monitor is off
    assign settle_load = !state_q.monitor_on;
    pmrc_counter #(
        .width(24)
    ) u_settle (
        .clk(clk),
        .rst_b(rst_b),
        .ce(ce),
        .load(settle_load),
        .load_value(24'(settle_cycles)),
        .count_en(1'b1),
        .done(settle_done)
    );

    // lost clock timeout
    // clock_edge_seen comes from the analog one-shot domain; it rearms the watch
    assign watch_load = clock_edge_seen || !state_q.lost_clock_en;
    pmrc_counter #(
        .width(24)
    ) u_watch (
        .clk(clk),
        .rst_b(rst_b),
        .ce(ce),
        .load(watch_load),
        .load_value(24'(lost_clock_limit)),
        .count_en(1'b1),
        .done(watch_done)
    );

    assign lost_clock = state_q.lost_clock_en && watch_done;

    // monitor resets need select; a selected monitor resets when off or on low supply
    assign monitor_fault = state_q.monitor_select && (!state_q.monitor_on || !supply_good);

    // suspend wake on usb event or matching bus power
    assign wake_event = usb_wake || (bus_power == bus_power_polarity);

    // =====================================================
    // apb decode; zero wait states
    assign word_addr = paddr[11:2];
    assign apb_write = psel && penable && pwrite;
    assign apb_read = psel && !penable && !pwrite;
    always_comb begin
        if (word_addr == pmrc_pkg::power_control_addr[9:2]) begin
            mapped = 1'b1;
        end else if (word_addr == pmrc_pkg::supply_monitor_control_addr[9:2]) begin
            mapped = 1'b1;
        end else if (word_addr == pmrc_pkg::reset_cause_addr[9:2]) begin
            mapped = 1'b1;
        end else begin
            mapped = 1'b0;
        end
    end

    // =====================================================
    // sequencer and registers
    always_comb begin
        state_d = state_q;
        // history of our own pin drive, matches the synchroniser depth
        state_d.pin_mask = {state_q.pin_mask[0], state_q.pin_drive};
        // read data captured in setup, held through access
        if (apb_read) begin
            state_d.rdata = 32'h0000_0000;
            if (word_addr == pmrc_pkg::power_control_addr[9:2]) begin
                state_d.rdata[7:0] = {state_q.flags, 2'b00};
            end else if (word_addr == pmrc_pkg::supply_monitor_control_addr[9:2]) begin
                state_d.rdata[pmrc_pkg::monitor_on_bit] = state_q.monitor_on;
                state_d.rdata[pmrc_pkg::above_bit] = supply_good;
            end else if (word_addr == pmrc_pkg::reset_cause_addr[9:2]) begin
                state_d.rdata[pmrc_pkg::pin_flag_bit] = state_q.pin_flag;
                state_d.rdata[pmrc_pkg::powerup_flag_bit] = state_q.powerup_flag;
                state_d.rdata[pmrc_pkg::lost_clock_bit] = state_q.lost_clock_flag;
            end
        end
        if (apb_write && state_q.state != pmrc_pkg::st_hold && state_q.state != pmrc_pkg::st_delay) begin
            if (word_addr == pmrc_pkg::power_control_addr[9:2]) begin
                state_d.flags = pwdata[7:pmrc_pkg::flags_lsb];
                state_d.idle_req = pwdata[pmrc_pkg::idle_bit];
                state_d.stop_req = pwdata[pmrc_pkg::stop_bit];
            end else if (word_addr == pmrc_pkg::supply_monitor_control_addr[9:2]) begin
                state_d.monitor_on = pwdata[pmrc_pkg::monitor_on_bit];
            end else if (word_addr == pmrc_pkg::reset_cause_addr[9:2]) begin
                state_d.monitor_select = pwdata[pmrc_pkg::powerup_flag_bit];
                if (pwdata[pmrc_pkg::powerup_flag_bit] && !settle_done) begin
                    state_d.sw_por = 1'b1;
                end
                state_d.lost_clock_en = pwdata[pmrc_pkg::lost_clock_bit];
                if (pwdata[pmrc_pkg::pin_flag_bit]) begin
                    state_d.sw_por = 1'b1;
                end
            end
        end
        case (state_q.state)
            pmrc_pkg::st_hold: begin
                state_d.pin_drive = (state_q.cause == pmrc_pkg::cause_power)
                    || (state_q.cause == pmrc_pkg::cause_monitor);
                if (supply_good && !pin_low) begin
                    state_d.state = pmrc_pkg::st_delay;
                end
            end
            pmrc_pkg::st_delay: begin
                if (!supply_good || pin_low) begin
                    state_d.state = pmrc_pkg::st_hold;
                end else if (delay_done) begin
                    state_d.state = pmrc_pkg::st_run;
                    state_d.pin_drive = 1'b0;
                    state_d.powerup_flag = (state_q.cause == pmrc_pkg::cause_power)
                        || (state_q.cause == pmrc_pkg::cause_monitor);
                    state_d.pin_flag = (state_q.cause == pmrc_pkg::cause_pin);
                    state_d.lost_clock_flag = (state_q.cause == pmrc_pkg::cause_lost_clock);
                end
            end
            pmrc_pkg::st_run: begin
                if (state_q.stop_req && instr_done) begin
                    state_d.state = pmrc_pkg::st_stop;
                    state_d.stop_req = 1'b0;
                    state_d.idle_req = 1'b0;
                end else if (state_q.idle_req && instr_done) begin
                    state_d.state = pmrc_pkg::st_idle;
                end
            end
            pmrc_pkg::st_idle: begin
                if (irq_pending) begin
                    state_d.idle_req = 1'b0;
                    state_d.state = pmrc_pkg::st_run;
                end
            end
            pmrc_pkg::st_stop: begin
                state_d.state = pmrc_pkg::st_stop;
            end
            default: begin
                state_d.state = pmrc_pkg::st_hold;
            end
        endcase
        // resets from any running state, priority power then pin then others
        // reset restarts the sequence
        if (state_q.state != pmrc_pkg::st_hold && state_q.state != pmrc_pkg::st_delay) begin
            if (state_q.sw_por) begin
                state_d.state = pmrc_pkg::st_hold;
                state_d.cause = pmrc_pkg::cause_power;
                state_d.monitor_on = 1'b1;
                state_d.monitor_select = 1'b0;
            end else if (pin_low) begin
                state_d.state = pmrc_pkg::st_hold;
                state_d.cause = pmrc_pkg::cause_pin;
            end else if (monitor_fault) begin
                state_d.state = pmrc_pkg::st_hold;
                state_d.cause = pmrc_pkg::cause_monitor;
            end else if (lost_clock) begin
                state_d.state = pmrc_pkg::st_hold;
                state_d.cause = pmrc_pkg::cause_lost_clock;
            end
            if (state_d.state == pmrc_pkg::st_hold) begin
                // power control bits back to reset values; lost clock enable kept, monitor kept except on power-on
                state_d.sw_por = 1'b0;
                state_d.flags = pmrc_pkg::general_flags_reset;
                state_d.idle_req = 1'b0;
                state_d.stop_req = 1'b0;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            state_q <= '0;
            state_q.state <= pmrc_pkg::st_hold;
            state_q.cause <= pmrc_pkg::cause_power;
            state_q.monitor_on <= 1'b1;
            state_q.pin_drive <= 1'b1;
        end else if (ce) begin
            state_q <= state_d;
        end
    end

    // =====================================================
    // apb answers
    assign pready = 1'b1;
    assign pslverr = psel && penable && !mapped;
    assign prdata = state_q.rdata;

    // =====================================================
    // core controls
    // core held in reset, restart at zero
    always_comb begin
        core_ctl.core_reset = (state_q.state == pmrc_pkg::st_hold)
            || (state_q.state == pmrc_pkg::st_delay);
        core_ctl.fetch_restart = core_ctl.core_reset;
        core_ctl.cpu_clock_en = (state_q.state == pmrc_pkg::st_run);
        core_ctl.periph_clock_en = (state_q.state != pmrc_pkg::st_stop);
        core_ctl.osc_run = (state_q.state != pmrc_pkg::st_stop) && (!osc_suspend || wake_event);
    end

    assign fetch_address = pmrc_pkg::start_address;
    // port latches ones in reset, pullups always on
    assign port_latch = pmrc_pkg::port_latch_reset;
    assign port_open_drain = core_ctl.core_reset;
    assign weak_pullup_en = 1'b1;
    assign reset_pin_out = 1'b0;
    assign reset_pin_oe = state_q.pin_drive;
    assign supply_monitor_on = state_q.monitor_on;
    assign general_flags = state_q.flags;
endmodule : power_modes_reset_control
`default_nettype wire

/* File: pmrc_props.sv */
// port checker for the power-mode and reset controller
// assumes it is bound onto the top module, ports matched by name
`timescale 1ns/100ps
`default_nettype none
module pmrc_props (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic ce,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic irq_pending,
    input wire logic reset_pin_oe,
    input wire pmrc_pkg::core_ctl_type core_ctl,
    input wire logic [15:0] fetch_address,
    input wire logic [7:0] port_latch,
    input wire logic port_open_drain,
    input wire logic weak_pullup_en,
    input wire logic supply_monitor_on,
    input wire logic [5:0] general_flags
);
    // ==========
    // access decode
    logic wr_pc;
    logic rd_pc;
    logic rd_mon;
    assign wr_pc = psel && penable && pwrite && ce && paddr == 12'h21c && !core_ctl.core_reset;
    assign rd_pc = psel && penable && !pwrite && paddr == 12'h21c;
    assign rd_mon = psel && penable && !pwrite && paddr == 12'h3fc;
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_b);
    // ==========
    // port state, pin release, register reads and power-mode checks
    port_known_a: assert property (port_latch == 8'hff && weak_pullup_en) else $error("port state");
    drain_reset_a: assert property (core_ctl.core_reset |-> port_open_drain) else $error("drain");
    start_zero_a: assert property ($fell(core_ctl.core_reset) |-> fetch_address == 16'h0000 && core_ctl.osc_run)
        else $error("exit state");
    pin_release_a: assert property ($fell(core_ctl.core_reset) |-> ##[0:1] !reset_pin_oe)
        else $error("pin held");
    flags_rw_a: assert property (wr_pc |=> general_flags == $past(pwdata[7:2])) else $error("flags");
    pc_read_a: assert property (rd_pc |-> prdata == {24'h000000, general_flags, 2'b00})
        else $error("pc read");
    mon_read_a: assert property (rd_mon |-> prdata[31:7] == {24'h000000, supply_monitor_on} && prdata[5:0] == 6'h00)
        else $error("mon read");
    irq_wake_a: assert property (!core_ctl.cpu_clock_en && core_ctl.periph_clock_en && !core_ctl.core_reset
        && irq_pending && ce |=> core_ctl.cpu_clock_en) else $error("no wake");
    stop_stays_a: assert property (!core_ctl.osc_run && !core_ctl.periph_clock_en && !core_ctl.core_reset
        |=> !core_ctl.osc_run || core_ctl.core_reset) else $error("stop left");
    keep_mon_a: assert property (core_ctl.core_reset && !reset_pin_oe |=> $stable(supply_monitor_on))
        else $error("mon changed");
endmodule : pmrc_props
bind power_modes_reset_control pmrc_props i_pmrc_props (.*);
`default_nettype wire

/* File: ext_reset_model.sv */
// board reset circuit on the open-drain reset pin
// assumes a pull-up: the wire is high unless a party sinks it
`timescale 1ns/100ps
`default_nettype none
module ext_reset_model (
    input wire logic pull_req,
    input wire logic dev_oe,
    output logic pin_n
);
    assign pin_n = !(pull_req || dev_oe);
endmodule : ext_reset_model
`default_nettype wire

/* File: power_modes_reset_control_tb.sv */
// bench for the power-mode and reset controller
// assumes the checker binds itself; pin model sits on the reset pin
`timescale 1ns/100ps
`default_nettype none
module power_modes_reset_control_tb;
    logic clk = 1'b0, rst_b = 1'b0, ce = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic instr_done = 1'b0, irq_pending = 1'b0, clock_edge_seen = 1'b1, osc_suspend = 1'b0;
    logic usb_event = 1'b0, bus_power = 1'b0, bus_power_polarity = 1'b0, supply_good_async = 1'b0;
    logic pull_req = 1'b0, reset_pin_n_in, reset_pin_out, reset_pin_oe, pready, pslverr, err;
    logic port_open_drain, weak_pullup_en, supply_monitor_on;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic [15:0] fetch_address;
    logic [7:0] port_latch;
    logic [5:0] general_flags;
    pmrc_pkg::core_ctl_type core_ctl;
    int miscompares = 0, checked = 0, cyc = 0, n;
    // short counts keep the run brief
    power_modes_reset_control #(.powerup_cycles(20), .lost_clock_limit(30), .settle_cycles(10))
        i_power_modes_reset_control (.*);
    ext_reset_model i_ext_reset_model (.pull_req(pull_req), .dev_oe(reset_pin_oe), .pin_n(reset_pin_n_in));
    always #20 clk = ~clk;
    // ==========
    // common tasks
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            miscompares++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        @(posedge clk);
        while (pready !== 1'b1) @(posedge clk);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task automatic rdc(input logic [11:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        chk(rd, exp);
    endtask : rdc
    task automatic pulse_done;
        @(posedge clk) instr_done <= 1'b1;
        @(posedge clk) instr_done <= 1'b0;
        @(negedge clk);
    endtask : pulse_done
    // wait for release; the global timeout bounds it
    task automatic wexit;
        n = 0;
        while (core_ctl.core_reset !== 1'b0) begin
            @(negedge clk);
            n++;
        end
    endtask : wexit
    // ==========
    // scenarios
    task automatic t_por;
        repeat (30) @(negedge clk);
        chk({core_ctl.core_reset, reset_pin_oe}, 2'b11);
        @(posedge clk) supply_good_async <= 1'b1;
        wexit;
        chk(n >= 20, 1'b1);
        chk({port_latch, fetch_address}, 24'hff0000);
        rdc(12'h3bc, 32'h2);
        rdc(12'h3fc, 32'hc0);
        apb(1'b0, 12'h010, 32'h0);
        chk({err, rd[30:0]}, 32'h80000000);
        apb(1'b1, 12'h21c, 32'ha8);
        rdc(12'h21c, 32'ha8);
        apb(1'b1, 12'h3fc, 32'hbf);
        rdc(12'h3fc, 32'hc0);
        $display("test por done");
    endtask : t_por
    task automatic t_idle_stop;
        apb(1'b1, 12'h21c, 32'h01);
        pulse_done;
        chk({core_ctl.cpu_clock_en, core_ctl.periph_clock_en}, 2'b01);
        rdc(12'h21c, 32'h0);
        @(posedge clk) irq_pending <= 1'b1;
        @(posedge clk) irq_pending <= 1'b0;
        @(negedge clk);
        chk(core_ctl.cpu_clock_en, 1'b1);
        apb(1'b1, 12'h21c, 32'hfe);
        pulse_done;
        chk({core_ctl.osc_run, core_ctl.periph_clock_en, core_ctl.cpu_clock_en}, 3'b000);
        @(posedge clk) irq_pending <= 1'b1;
        @(posedge clk) irq_pending <= 1'b0;
        @(posedge clk) pull_req <= 1'b1;
        repeat (8) @(posedge clk);
        @(negedge clk);
        chk({core_ctl.core_reset, core_ctl.osc_run}, 2'b11);
        @(posedge clk) pull_req <= 1'b0;
        wexit;
        rdc(12'h3bc, 32'h1);
        rdc(12'h21c, 32'h0);
        $display("test idle stop done");
    endtask : t_idle_stop
    task automatic t_lost;
        apb(1'b1, 12'h3bc, 32'h4);
        apb(1'b1, 12'h21c, 32'h02);
        pulse_done;
        @(posedge clk) clock_edge_seen <= 1'b0;
        n = 0;
        while (core_ctl.core_reset !== 1'b1 && n < 100) begin
            @(negedge clk);
            n++;
        end
        chk({n > 20 && n < 40, reset_pin_oe}, 2'b10);
        @(posedge clk) clock_edge_seen <= 1'b1;
        wexit;
        rdc(12'h3bc, 32'h4);
        $display("test lost clock done");
    endtask : t_lost
    task automatic t_mon;
        apb(1'b1, 12'h3fc, 32'h0);
        rdc(12'h3fc, 32'h40);
        apb(1'b1, 12'h3bc, 32'h1);
        repeat (3) @(negedge clk);
        chk({core_ctl.core_reset, reset_pin_oe}, 2'b11);
        wexit;
        rdc(12'h3bc, 32'h2);
        rdc(12'h3fc, 32'hc0);
        apb(1'b1, 12'h3fc, 32'h0);
        apb(1'b1, 12'h3fc, 32'h80);
        apb(1'b1, 12'h3bc, 32'h2);
        repeat (3) @(negedge clk);
        chk(core_ctl.core_reset, 1'b1);
        wexit;
        repeat (15) @(negedge clk);
        apb(1'b1, 12'h3bc, 32'h2);
        repeat (3) @(negedge clk);
        chk(core_ctl.core_reset, 1'b0);
        @(posedge clk) supply_good_async <= 1'b0;
        repeat (6) @(negedge clk);
        chk({core_ctl.core_reset, reset_pin_oe}, 2'b11);
        @(posedge clk) supply_good_async <= 1'b1;
        wexit;
        rdc(12'h3bc, 32'h2);
        $display("test monitor done");
    endtask : t_mon
    task automatic summarize;
        $display("checked %0d miscompares %0d", checked, miscompares);
        if (miscompares == 0 && checked > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : summarize
    // hang guard, far beyond the expected run
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            miscompares++;
            summarize();
        end
    end
    initial begin
        repeat (12) @(posedge clk);
        rst_b <= 1'b1;
        t_por();
        t_idle_stop();
        t_lost();
        t_mon();
        summarize();
    end
endmodule : power_modes_reset_control_tb
`default_nettype wire
